//--- src/mdio_pkg.sv
package mdio_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD_RAW = 8'h04;
  localparam logic [7:0] OFS_LINK_RAW = 8'h08;
  localparam logic [7:0] OFS_LINK_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_CMD0 = 8'h20;
  localparam logic [7:0] OFS_PHYSEL0 = 8'h24;
  localparam logic [7:0] OFS_CMD1 = 8'h28;
  // command register fields
  localparam int GO_BIT = 31;
  localparam int WR_BIT = 30;
  localparam int ACK_BIT = 29;
  localparam int REG_HI = 25;
  localparam int REG_LO = 21;
  localparam int PHY_HI = 20;
  localparam int PHY_LO = 16;
  localparam int DATA_HI = 15;
  // phy select fields
  localparam int LSEL_BIT = 7;
  localparam int LIEN_BIT = 6;
  localparam int MON_HI = 4;
  // interrupt status bits
  localparam int IRQ_LINK = 2;
  // reset values
  localparam logic [31:0] CMD_RST = 32'h00000000;
  localparam logic [7:0] PHYSEL_RST = 8'h00;
  // frame layout, in bit slots
  localparam logic [31:0] PREAMBLE = 32'hFFFFFFFF;
  localparam logic [1:0] ST_CODE = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [6:0] FRAME_BITS = 7'h40;
  localparam logic [6:0] RD_RELEASE = 7'h2E;
  localparam logic [6:0] TA_SAMPLE = 7'h30;
  // link polling of the monitored phy
  localparam logic [4:0] POLL_REG = 5'h01;
  localparam int LINK_BIT = 2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD0 = 2'b01,
    ST_CMD1 = 2'b10,
    ST_POLL = 2'b11
  } arb_state_t;
endpackage

//--- src/mdio_frame_if.sv
`timescale 1ns/1ns
interface mdio_frame_if;
  logic start;
  logic wr;
  logic [4:0] phy;
  logic [4:0] regn;
  logic [15:0] wdata;
  logic busy;
  logic done;
  logic ack;
  logic [15:0] rdata;
  modport ctrl (output start, wr, phy, regn, wdata, input busy, done, ack, rdata);
  modport eng (input start, wr, phy, regn, wdata, output busy, done, ack, rdata);
endinterface

//--- src/mdio_sync2.sv
`timescale 1ns/1ns
module mdio_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);
  logic [1:0] meta_r;

  // two-stage synchroniser, first stage read only here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 2'h0;
      sync_o <= 2'h0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // mdio_sync2

//--- src/mdio_shifter.sv
`timescale 1ns/1ns
module mdio_shifter
  import mdio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mdc_s_i,
  input wire logic mdio_s_i,
  mdio_frame_if.eng frame,
  output logic mdio_o,
  output logic mdio_oe_n_o
);
  logic [63:0] sh_r;
  logic [6:0] cnt_r;
  logic busy_r, done_r, ack_r, rd_r, mdc_q_r, mdio_q_r;
  logic [15:0] rdata_r;

  // edges of the sampled management clock
  wire fall_w = mdc_q_r & ~mdc_s_i;
  wire rise_w = ~mdc_q_r & mdc_s_i;
  wire load_w = frame.start & ~busy_r;
  wire last_w = cnt_r == FRAME_BITS;
  wire [63:0] frame_w = {PREAMBLE, ST_CODE, frame.wr ? OP_WRITE : OP_READ, frame.phy, frame.regn,
                         frame.wr ? TA_WRITE : 2'h3, frame.wr ? frame.wdata : 16'hFFFF};

  assign frame.busy = busy_r;
  assign frame.done = done_r;
  assign frame.ack = ack_r;
  assign frame.rdata = rdata_r;

  // shift out on falling edge, sample on rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= 64'h0; cnt_r <= 7'h0; busy_r <= 1'b0; done_r <= 1'b0; rd_r <= 1'b0;
      ack_r <= 1'b0; rdata_r <= 16'h0; mdc_q_r <= 1'b0; mdio_o <= 1'b1; mdio_oe_n_o <= 1'b1;
      mdio_q_r <= 1'b1;
    end else begin
      mdc_q_r <= mdc_s_i;
      mdio_q_r <= mdio_s_i; // line level just before the clock edge, phy may change it right after
      done_r <= 1'b0;
      if (load_w) begin
        sh_r <= frame_w;
        cnt_r <= 7'h0;
        busy_r <= 1'b1;
        rd_r <= ~frame.wr;
        ack_r <= 1'b0;
      end else if (busy_r && fall_w && last_w) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        mdio_oe_n_o <= 1'b1;
      end else if (busy_r && fall_w) begin
        mdio_o <= sh_r[63];
        sh_r <= {sh_r[62:0], 1'b1};
        mdio_oe_n_o <= rd_r && (cnt_r >= RD_RELEASE);
        cnt_r <= cnt_r + 7'h1;
      end else if (busy_r && rise_w && rd_r) begin
        if (cnt_r == TA_SAMPLE) ack_r <= ~mdio_q_r;
        if (cnt_r > TA_SAMPLE) rdata_r <= {rdata_r[14:0], mdio_q_r};
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_op_code: assert property (load_w |=> sh_r[29:28] == ($past(frame.wr) ? OP_WRITE : OP_READ))
    else $error("opcode does not follow direction");
  a_addr_fields: assert property (load_w |=> sh_r[27:23] == $past(frame.phy) && sh_r[22:18] == $past(frame.regn))
    else $error("frame address fields wrong");
  a_read_release: assert property (busy_r && rd_r && cnt_r > RD_RELEASE |-> mdio_oe_n_o)
    else $error("pin driven in read data phase");
endmodule // mdio_shifter

//--- src/mdio_cmd_access.sv
`timescale 1ns/1ns
module mdio_cmd_access
  import mdio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  output logic irq_o
);
  mdio_frame_if frame ();

  logic [1:0] pin_s;
  logic en_r;
  logic [31:0] cmd_r [2];
  logic [31:0] cmd_nxt [2];
  logic [7:0] physel_r;
  logic [1:0] cmd_raw_r;
  logic link_raw_r;
  logic link_r;
  logic link_valid_r;
  logic [4:0] poll_phy_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_stat_nxt;
  logic [2:0] irq_mask_r;
  arb_state_t state_r;
  arb_state_t state_nxt;
  logic start_r;
  logic start_nxt;

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[8*i+:8] = new_v[8*i+:8];
    end
    return res;
  endfunction

  // pins cross into the clock domain
  mdio_sync2 u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({mdc_i, mdio_i}),
    .sync_o(pin_s)
  );

  // frame serialiser
  mdio_shifter u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mdc_s_i(pin_s[1]),
    .mdio_s_i(pin_s[0]),
    .frame(frame),
    .mdio_o(mdio_o),
    .mdio_oe_n_o(mdio_oe_n_o)
  );

  // bus access decode
  logic wb_ack_r;
  wire acc_w = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  wire wr_w = acc_w & wb_we_i;
  wire rd_w = acc_w & ~wb_we_i;
  wire [7:0] adr_w = {wb_adr_i[7:2], 2'b00};
  wire hit_ctrl = adr_w == OFS_CTRL;
  wire hit_cmd_raw = adr_w == OFS_CMD_RAW;
  wire hit_link_raw = adr_w == OFS_LINK_RAW;
  wire hit_link_stat = adr_w == OFS_LINK_STAT;
  wire hit_irq_stat = adr_w == OFS_IRQ_STAT;
  wire hit_irq_mask = adr_w == OFS_IRQ_MASK;
  wire hit_physel = adr_w == OFS_PHYSEL0;
  wire [1:0] hit_cmd = {adr_w == OFS_CMD1, adr_w == OFS_CMD0};
  wire [31:0] wmerge_w = merge_bytes(32'h0, wb_dat_i, wb_sel_i);

  // engine results
  wire done_w = frame.done;
  wire [1:0] cmd_done_w = {done_w & (state_r == ST_CMD1), done_w & (state_r == ST_CMD0)};
  wire poll_done_w = done_w & (state_r == ST_POLL);
  wire new_link_w = frame.ack & frame.rdata[LINK_BIT];
  wire poll_ok_w = poll_done_w & (poll_phy_r == physel_r[MON_HI:0]); // stale poll of an old phy ignored
  wire link_chg_w = poll_ok_w & link_valid_r & (new_link_w != link_r);
  wire [1:0] go_w = {cmd_r[1][GO_BIT], cmd_r[0][GO_BIT]};

  // fields handed to the serialiser
  wire is_cmd_w = (state_r == ST_CMD0) | (state_r == ST_CMD1);
  wire [31:0] cur_cmd_w = (state_r == ST_CMD1) ? cmd_r[1] : cmd_r[0];
  assign frame.start = start_r;
  assign frame.wr = is_cmd_w & cur_cmd_w[WR_BIT];
  assign frame.phy = is_cmd_w ? cur_cmd_w[PHY_HI:PHY_LO] : physel_r[MON_HI:0];
  assign frame.regn = is_cmd_w ? cur_cmd_w[REG_HI:REG_LO] : POLL_REG;
  assign frame.wdata = cur_cmd_w[DATA_HI:0];

  // command register next values
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    for (int i = 0; i < 2; i++) begin
      m = merge_bytes(cmd_r[i], wb_dat_i, wb_sel_i);
      cmd_nxt[i] = cmd_r[i];
      if (wr_w && hit_cmd[i] && !cmd_r[i][GO_BIT]) begin
        cmd_nxt[i] = {m[GO_BIT] & en_r, m[WR_BIT], cmd_r[i][ACK_BIT], 3'h0, m[REG_HI:0]};
      end
      if (cmd_done_w[i]) begin
        cmd_nxt[i][GO_BIT] = 1'b0;
        cmd_nxt[i][ACK_BIT] = ~cmd_r[i][WR_BIT] & frame.ack;
        if (!cmd_r[i][WR_BIT]) cmd_nxt[i][DATA_HI:0] = frame.rdata;
      end
    end
  end

  // one access at a time, user commands before link polling
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (en_r && !frame.busy) begin
          start_nxt = 1'b1;
          if (go_w[0]) state_nxt = ST_CMD0;
          else if (go_w[1]) state_nxt = ST_CMD1;
          else state_nxt = ST_POLL;
        end
      end
      ST_CMD0, ST_CMD1, ST_POLL: begin
        if (done_w) state_nxt = ST_IDLE;
      end
    endcase
  end

  // sticky interrupt status, read clears, set wins
  wire [2:0] irq_set_w = {link_chg_w & physel_r[LIEN_BIT], cmd_done_w};
  assign irq_stat_nxt = ((rd_w && hit_irq_stat) ? 3'h0 : irq_stat_r) | irq_set_w;

  // register read mux
  wire [31:0] rdata_w =
    hit_ctrl ? {31'h0, en_r} :
    hit_cmd_raw ? {30'h0, cmd_raw_r} :
    hit_link_raw ? {31'h0, link_raw_r} :
    hit_link_stat ? {29'h0, frame.busy, link_valid_r, link_r} :
    hit_irq_stat ? {29'h0, irq_stat_r} :
    hit_irq_mask ? {29'h0, irq_mask_r} :
    hit_physel ? {24'h0, physel_r} :
    hit_cmd[0] ? cmd_r[0] :
    hit_cmd[1] ? cmd_r[1] : 32'h0;

  // bus slave, one wait state then ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_r <= acc_w;
      wb_dat_o <= rd_w ? rdata_w : 32'h0;
    end
  end
  assign wb_ack_o = wb_ack_r;

  // command registers and arbiter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r[0] <= CMD_RST;
      cmd_r[1] <= CMD_RST;
      state_r <= ST_IDLE;
      start_r <= 1'b0;
    end else begin
      cmd_r[0] <= cmd_nxt[0];
      cmd_r[1] <= cmd_nxt[1];
      state_r <= state_nxt;
      start_r <= start_nxt;
    end
  end

  // enable and phy select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= 1'b0;
      physel_r <= PHYSEL_RST;
    end else begin
      if (wr_w && hit_ctrl && wb_sel_i[0]) en_r <= wb_dat_i[0];
      if (wr_w && hit_physel && wb_sel_i[0]) begin
        physel_r <= {1'b0, wb_dat_i[LIEN_BIT], 1'b0, wb_dat_i[MON_HI:0]};
      end
    end
  end

  // raw event bits, write one clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_raw_r <= 2'h0;
      link_raw_r <= 1'b0;
    end else begin
      cmd_raw_r <= (cmd_raw_r & ~((wr_w && hit_cmd_raw) ? wmerge_w[1:0] : 2'h0)) | cmd_done_w;
      link_raw_r <= (link_raw_r & ~(wr_w & hit_link_raw & wmerge_w[0])) | link_chg_w;
    end
  end

  // tracked link state of the monitored phy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_r <= 1'b0;
      link_valid_r <= 1'b0;
    end else if (wr_w && hit_physel && wb_sel_i[0]) begin
      link_valid_r <= 1'b0; // new phy, no false change
    end else if (poll_ok_w) begin
      link_r <= new_link_w;
      link_valid_r <= 1'b1;
    end
  end

  // phy addressed by the frame now running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      poll_phy_r <= 5'h00;
    end else if (start_r) begin
      poll_phy_r <= frame.phy;
    end
  end

  // interrupt status, mask and output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_w && hit_irq_mask && wb_sel_i[0]) irq_mask_r <= wb_dat_i[2:0];
      irq_o <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_go_needs_enable: assert property (wr_w && hit_cmd[0] && !en_r && !go_w[0] |=> !go_w[0])
    else $error("start bit set while disabled");
  a_zero_keeps_go: assert property (wr_w && hit_cmd[1] && !wb_dat_i[GO_BIT] && !go_w[1] |=> !go_w[1])
    else $error("zero write set start bit");
  a_go_sets: assert property (wr_w && hit_cmd[0] && en_r && !go_w[0] && wb_dat_i[GO_BIT] && wb_sel_i[3]
                              |=> go_w[0])
    else $error("start bit not taken");
  a_busy_write_blocked: assert property (wr_w && hit_cmd[0] && go_w[0] && !cmd_done_w[0]
                                         |=> cmd_r[0] == $past(cmd_r[0]))
    else $error("write altered busy command");
  a_go_self_clear: assert property (cmd_done_w[1] |=> !go_w[1] && cmd_raw_r[1])
    else $error("start bit did not clear on completion");
  a_read_data_back: assert property (cmd_done_w[0] && !cmd_r[0][WR_BIT]
                                     |=> cmd_r[0][DATA_HI:0] == $past(frame.rdata)
                                         && cmd_r[0][ACK_BIT] == $past(frame.ack))
    else $error("read result not stored");
  a_write_no_ack: assert property (cmd_done_w[0] && cmd_r[0][WR_BIT] |=> !cmd_r[0][ACK_BIT])
    else $error("ack set on a write");
  a_done_event: assert property (cmd_done_w[0] && !(wr_w && hit_cmd_raw) |=> cmd_raw_r[0] ##1 cmd_raw_r[0]
                                 or (wr_w && hit_cmd_raw))
    else $error("done event lost");
  a_link_gated: assert property (link_chg_w && !physel_r[LIEN_BIT] && !irq_stat_r[IRQ_LINK]
                                 |=> !irq_stat_r[IRQ_LINK] && link_raw_r)
    else $error("link interrupt not gated");
  a_link_sel_zero: assert property (rd_w && hit_physel |=> !wb_dat_o[LSEL_BIT])
    else $error("link source select not zero");
  a_one_frame: assert property (start_r |-> !frame.busy ##1 frame.busy)
    else $error("frame started while busy");
  a_irq_level: assert property (irq_stat_r == 3'h0 ##1 irq_stat_r == 3'h0 |-> !irq_o)
    else $error("interrupt without status");

  c_write_done: cover property (cmd_done_w[0] && cmd_r[0][WR_BIT]);
  c_read_acked: cover property (cmd_done_w[1] && !cmd_r[1][WR_BIT] && frame.ack);
  c_link_change: cover property (link_chg_w && physel_r[LIEN_BIT]);
  c_irq_raised: cover property ($rose(irq_o));
endmodule // mdio_cmd_access

//--- tb/mdio_phy_model.sv
`timescale 1ns/1ns
module mdio_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h03
) (
  input wire logic mdc_i,
  input wire logic dev_d_i,
  input wire logic dev_oe_n_i,
  input wire logic link_i,
  output logic line_o
);
  logic [15:0] regs [0:31];
  logic [5:0] slot;
  logic [12:0] hdr;
  logic [15:0] sh;
  logic drv;
  logic dq;
  wire logic mine = hdr[9:5] == PHY_ADDR;
  wire logic rd_op = hdr[11:10] == 2'b10;
  wire logic [15:0] rd_val = (hdr[4:0] == 5'h01) ? {regs[1][15:3], link_i, regs[1][1:0]} : regs[hdr[4:0]];
  // wire level, pulled up when nobody drives
  assign line_o = !dev_oe_n_i ? dev_d_i : (drv ? dq : 1'b1);
  initial begin
    slot = 6'h00;
    drv = 1'b0;
    dq = 1'b1;
    hdr = 13'h0000;
    sh = 16'h0000;
    foreach (regs[i]) regs[i] = 16'h0000;
  end
  // frame tracker, first zero after preamble is the start code
  always @(posedge mdc_i) begin
    if (slot == 6'h00) begin
      if (!dev_oe_n_i && !dev_d_i) slot <= 6'h21;
    end else begin
      slot <= (slot == 6'h3F) ? 6'h00 : slot + 6'h01;
      if (slot <= 6'h2D) hdr <= {hdr[11:0], line_o};
      if (slot == 6'h2E && rd_op && mine) begin
        drv <= 1'b1;
        dq <= 1'b0;
        sh <= rd_val;
      end else if (drv && slot < 6'h3F) begin
        dq <= sh[15];
        sh <= {sh[14:0], 1'b0};
      end else if (!rd_op && slot >= 6'h30) begin
        sh <= {sh[14:0], line_o};
      end
      if (slot == 6'h3F) drv <= 1'b0;
      if (slot == 6'h3F && !rd_op && mine) regs[hdr[4:0]] <= {sh[14:0], line_o};
    end
  end
endmodule // mdio_phy_model

//--- tb/mdio_cmd_access_tb.sv
`timescale 1ns/1ns
module mdio_cmd_access_tb;
  import mdio_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, mdc, link_up, line;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat, wb_q, wb_dat_o;
  logic wb_ack_o, mdio_o, mdio_oe_n_o, irq_o;
  int fail_count, tests_run;
  mdio_cmd_access mdio_cmd_access_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mdc_i(mdc), .mdio_i(line), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .irq_o(irq_o));
  mdio_phy_model #(.PHY_ADDR(5'h03)) mdio_phy_model_i (.mdc_i(mdc), .dev_d_i(mdio_o), .dev_oe_n_i(mdio_oe_n_o),
    .link_i(link_up), .line_o(line));
  // system clock and free-running management clock, phase offset
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    mdc = 1'b0;
    #3;
    forever #80 mdc = ~mdc;
  end
  task print_verdict;
    $display("checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // one classic cycle, held until ack is seen at a rising edge
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    // ack and read data taken at the rising edge that sees ack high
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    wb_q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, wb_ack_o}, 32'h0, "ack not dropped");
  endtask
  task wait_go(input logic [7:0] a);
    for (int i = 0; i < 400; i++) begin
      wb(a, 1'b0, 32'h0);
      if (wb_q[GO_BIT] === 1'b0) break;
      repeat (10) @(posedge clk_i);
    end
    chk({31'h0, wb_q[GO_BIT]}, 32'h0, "start bit stuck");
  endtask
  task t_reset_disabled;
    wb(OFS_CMD0, 1'b0, 32'h0);
    chk(wb_q, CMD_RST, "cmd0 reset");
    wb(OFS_PHYSEL0, 1'b0, 32'h0);
    chk(wb_q, {24'h000000, PHYSEL_RST}, "physel reset");
    wb(OFS_CMD1, 1'b0, 32'h0);
    chk(wb_q, CMD_RST, "cmd1 reset");
    wb(8'hFC, 1'b0, 32'h0);
    chk(wb_q, 32'h0, "unmapped read");
    wb(OFS_CMD0, 1'b1, 32'h80A30000);
    wb(OFS_CMD0, 1'b0, 32'h0);
    chk({31'h0, wb_q[GO_BIT]}, 32'h0, "start set while disabled");
  endtask
  task t_write_cmd;
    wb(OFS_CTRL, 1'b1, 32'h1);
    wb(OFS_CMD1, 1'b1, 32'h00001234);
    repeat (50) @(posedge clk_i);
    wb(OFS_CMD1, 1'b0, 32'h0);
    chk(wb_q, 32'h00001234, "zero start bit");
    wb(OFS_CMD0, 1'b1, 32'hC0A3A5C3);
    wb(OFS_CMD0, 1'b1, 32'h00000000);
    wb(OFS_CMD0, 1'b0, 32'h0);
    chk(wb_q, 32'hC0A3A5C3, "busy command changed");
    wait_go(OFS_CMD0);
    chk(wb_q, 32'h40A3A5C3, "finished write");
    chk({16'h0, mdio_phy_model_i.regs[5]}, 32'h0000A5C3, "phy register");
    wb(OFS_CMD_RAW, 1'b0, 32'h0);
    chk(wb_q, 32'h1, "done event");
    chk({31'h0, irq_o}, 32'h0, "masked irq");
    wb(OFS_CMD_RAW, 1'b1, 32'h1);
    wb(OFS_CMD_RAW, 1'b0, 32'h0);
    chk(wb_q, 32'h0, "done event clear");
  endtask
  task t_read_pair;
    wb(OFS_CMD0, 1'b1, 32'h80A30000);
    wb(OFS_CMD1, 1'b1, 32'h805F0000);
    wait_go(OFS_CMD0);
    chk(wb_q, 32'h20A3A5C3, "read with ack");
    wb(OFS_CMD1, 1'b0, 32'h0);
    chk({31'h0, wb_q[GO_BIT]}, 32'h1, "second command overlapped");
    wait_go(OFS_CMD1);
    chk(wb_q & 32'hFFFF0000, 32'h005F0000, "read without ack");
    wb(OFS_CMD_RAW, 1'b0, 32'h0);
    chk(wb_q, 32'h3, "both done");
  endtask
  task t_link_irq;
    wb(OFS_IRQ_STAT, 1'b0, 32'h0);
    wb(OFS_IRQ_MASK, 1'b1, 32'h7);
    wb(OFS_PHYSEL0, 1'b1, 32'h00000043);
    repeat (2500) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0, "irq before change");
    link_up <= 1'b1;
    for (int i = 0; i < 4000 && irq_o !== 1'b1; i++) @(negedge clk_i);
    chk({31'h0, irq_o}, 32'h1, "link irq");
    wb(OFS_LINK_RAW, 1'b0, 32'h0);
    chk(wb_q, 32'h1, "link event");
    wb(OFS_IRQ_STAT, 1'b0, 32'h0);
    chk(wb_q, 32'h4, "irq status");
    wb(OFS_LINK_RAW, 1'b1, 32'h1);
    wb(OFS_LINK_RAW, 1'b0, 32'h0);
    chk(wb_q, 32'h0, "link event clear");
    chk({31'h0, irq_o}, 32'h0, "irq after clear");
    wb(OFS_PHYSEL0, 1'b1, 32'h00000083);
    wb(OFS_PHYSEL0, 1'b0, 32'h0);
    chk(wb_q, 32'h00000003, "physel readback");
    repeat (2500) @(posedge clk_i);
    link_up <= 1'b0;
    repeat (3000) @(posedge clk_i);
    wb(OFS_IRQ_STAT, 1'b0, 32'h0);
    chk(wb_q, 32'h0, "suppressed link irq");
    chk({31'h0, irq_o}, 32'h0, "irq stays low");
    wb(OFS_LINK_RAW, 1'b0, 32'h0);
    chk(wb_q, 32'h1, "link event with irq off");
  endtask
  // main sequence
  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    link_up = 1'b0;
    fail_count = 0;
    tests_run = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_disabled;
    t_write_cmd;
    t_read_pair;
    t_link_irq;
    print_verdict;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (80000) @(posedge clk_i);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule // mdio_cmd_access_tb
